// ---- src/rtc_calendar_counters.sv ----
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "rtc_consts.svh"

// Behaviour
// - Stopwatch holds when stopped, resumes from hold
// - Stopwatch stops at next stopwatch tick
// - Seconds are two BCD digits, 0 to 59
// - Seconds word shows divider stages 1..128 Hz
// - Divider stages clear on divider reset
// - PM bit readable and writable in 12-hour mode
// - PM reads 0, writes store 0 in 24h
// - Stale PM clears at next hour increment
// - Minutes are two BCD digits, 0 to 59
// - Month is BCD 1 to 12
// - Day BCD, last day follows month, leap
// - Weekday counts 0 to 6, Sunday first
// - Year is two BCD digits, 0 to 99
// - One flag per event, write one clears
// - Mode bit selects 24-hour or 12-hour range
// - Divider reset bit reads 1 until done
module rtc_calendar_counters #(
   parameter int unsigned SRC_TICK_CYCLES = `RTC_CLK_HZ / `RTC_SRC_HZ,
   parameter int unsigned SW_TICK_CYCLES = `RTC_CLK_HZ / `RTC_SW_HZ
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Avalon-MM slave, word addressed
   input wire logic [2:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Events from neighbouring logic on this clock
   input wire logic alarm_event_i,
   input wire logic regulation_done_i,
   // Flag state
   output logic [15:0] event_flags_o
);

   localparam logic [31:0] SRC_LAST = 32'(SRC_TICK_CYCLES - 1);
   localparam logic [31:0] SW_LAST = 32'(SW_TICK_CYCLES - 1);
   localparam logic [31:0] BUSY_FROM =
      32'(SRC_TICK_CYCLES - `RTC_BUSY_CYCLES);

   rtc_pkg::calendar_t cal_reg, cal_next;
   rtc_pkg::carry_t cy;
   logic wait_reg, wr_acc, rd_acc;
   logic [31:0] rdata_reg;
   logic [15:0] cur_word, wword, wmask, flags_reg, flag_set;
   logic run_reg, mode24_reg, divrst_reg, busy_reg;
   logic [31:0] src_cnt_reg, sw_cnt_reg;
   logic [7:0] div_reg, sw_val_reg;
   logic sw_run_reg, sw_active_reg;
   logic src_tick, sec_tick, sw_tick, sw_count;

   // Two-digit BCD increment; callers handle their own wrap point
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction : bcd_inc

   // Last day of a month; every year divisible by four is a leap year
   function automatic logic [5:0] month_last(input logic [4:0] m,
                                             input logic [7:0] y);
      logic leap;
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      unique case (m)
         5'h02: month_last = leap ? 6'h29 : 6'h28;
         5'h04, 5'h06, 5'h09, 5'h11: month_last = 6'h30;
         default: month_last = 6'h31;
      endcase
   endfunction : month_last

   // Bus handshake: one wait state, then the access completes
   assign rd_acc = avs_read_i && !wait_reg;
   assign wr_acc = avs_write_i && !wait_reg;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= !((avs_read_i || avs_write_i) && wait_reg);
      end
   end

   // Current value of the addressed word, reserved bits read zero
   always_comb begin
      cur_word = 16'h0000;
      unique case (avs_address_i)
         `RTC_IDX_CTRL: begin
            cur_word[`RTC_CTRL_RUN] = run_reg;
            cur_word[`RTC_CTRL_DIVRST] = divrst_reg;
            cur_word[`RTC_CTRL_24H] = mode24_reg;
            cur_word[`RTC_CTRL_BUSY] = busy_reg;
         end
         `RTC_IDX_SWCTL: cur_word = {sw_val_reg, 7'h00, sw_run_reg};
         `RTC_IDX_SEC: cur_word = {1'b0, cal_reg.sec, div_reg};
         `RTC_IDX_HURMIN: cur_word = {1'b0, cal_reg.pm && !mode24_reg,
                                       cal_reg.hour, 1'b0, cal_reg.min};
         `RTC_IDX_MONDAY: cur_word = {3'h0, cal_reg.mon, 2'h0, cal_reg.day};
         `RTC_IDX_YEARWK: cur_word = {5'h00, cal_reg.wk, cal_reg.year};
         `RTC_IDX_FLAGS: cur_word = flags_reg;
         default: cur_word = 16'h0000;
      endcase
   end

   // Byte lanes not enabled keep their current contents
   assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign wword = (avs_writedata_i[15:0] & wmask) | (cur_word & ~wmask);

   // Read data is latched as waitrequest drops and stands with it
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read_i && wait_reg) begin
         rdata_reg <= {16'h0000, cur_word};
      end
   end

   // Control bits written by software
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_reg <= 1'b0;
         mode24_reg <= 1'b0;
         sw_run_reg <= 1'b0;
      end else if (wr_acc && avs_address_i == `RTC_IDX_CTRL) begin
         run_reg <= wword[`RTC_CTRL_RUN];
         mode24_reg <= wword[`RTC_CTRL_24H];
      end else if (wr_acc && avs_address_i == `RTC_IDX_SWCTL) begin
         sw_run_reg <= wword[`RTC_SW_RUN];
      end
   end

   // Divider reset request lasts one cycle and reads 1 meanwhile
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         divrst_reg <= 1'b0;
      end else begin
         divrst_reg <= wr_acc && avs_address_i == `RTC_IDX_CTRL &&
                       wword[`RTC_CTRL_DIVRST];
      end
   end

   // Source prescaler: one divider step per 1/256 second while running
   assign src_tick = run_reg && src_cnt_reg == SRC_LAST;
   assign sec_tick = src_tick && div_reg == 8'hff;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src_cnt_reg <= 32'h0000_0000;
      end else if (divrst_reg || src_tick) begin
         src_cnt_reg <= 32'h0000_0000;
      end else if (run_reg) begin
         src_cnt_reg <= src_cnt_reg + 32'h0000_0001;
      end
   end

   // Divider stages 128 Hz .. 1 Hz, cleared by the divider reset
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_reg <= 8'h00;
      end else if (divrst_reg) begin
         div_reg <= 8'h00;
      end else if (src_tick) begin
         div_reg <= div_reg + 8'h01;
      end
   end

   // Busy shortly before and during the second carry; software must
   // not write the calendar then, as the carry still steps the fields not written
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= run_reg && div_reg == 8'hff &&
                     src_cnt_reg >= BUSY_FROM;
      end
   end

   // Calendar carry chain evaluated in one cycle
   always_comb begin
      cal_next = cal_reg;
      cy = '0;
      if (sec_tick) begin
         if (cal_reg.sec == 7'h59) begin
            cal_next.sec = 7'h00;
            cy.min = 1'b1;
         end else begin
            cal_next.sec = 7'(bcd_inc({1'b0, cal_reg.sec}));
         end
      end
      if (cy.min) begin
         if (cal_reg.min == 7'h59) begin
            cal_next.min = 7'h00;
            cy.hour = 1'b1;
         end else begin
            cal_next.min = 7'(bcd_inc({1'b0, cal_reg.min}));
         end
      end
      if (cy.hour) begin
         if (mode24_reg) begin
            cal_next.pm = 1'b0;
            if (cal_reg.hour == 6'h23) begin
               cal_next.hour = 6'h00;
               cy.day = 1'b1;
            end else begin
               cal_next.hour = 6'(bcd_inc({2'b00, cal_reg.hour}));
            end
         end else if (cal_reg.hour == 6'h12) begin
            cal_next.hour = 6'h01;
         end else if (cal_reg.hour == 6'h11) begin
            cal_next.hour = 6'h12;
            cal_next.pm = !cal_reg.pm;
            cy.day = cal_reg.pm;
         end else begin
            cal_next.hour = 6'(bcd_inc({2'b00, cal_reg.hour}));
         end
      end
      if (cy.day) begin
         cal_next.wk = cal_reg.wk == 3'h6 ? 3'h0 : cal_reg.wk + 3'h1;
         if (cal_reg.day >= month_last(cal_reg.mon, cal_reg.year)) begin
            cal_next.day = 6'h01;
            cy.mon = 1'b1;
         end else begin
            cal_next.day = 6'(bcd_inc({2'b00, cal_reg.day}));
         end
      end
      if (cy.mon) begin
         if (cal_reg.mon == 5'h12) begin
            cal_next.mon = 5'h01;
            cal_next.year = cal_reg.year == 8'h99 ? 8'h00
                                                  : bcd_inc(cal_reg.year);
         end else begin
            cal_next.mon = 5'(bcd_inc({3'b000, cal_reg.mon}));
         end
      end
   end

   // Calendar update; a software write replaces its own fields
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cal_reg <= '0;
         cal_reg.hour <= `RTC_RST_HOUR;
         cal_reg.mon <= `RTC_RST_MON;
         cal_reg.day <= `RTC_RST_DAY;
      end else begin
         cal_reg <= cal_next;
         if (wr_acc && avs_address_i == `RTC_IDX_SEC) begin
            cal_reg.sec <= wword[14:8];
         end
         if (wr_acc && avs_address_i == `RTC_IDX_HURMIN) begin
            cal_reg.pm <= wword[`RTC_PM_BIT] && !mode24_reg;
            cal_reg.hour <= wword[13:8];
            cal_reg.min <= wword[6:0];
         end
         if (wr_acc && avs_address_i == `RTC_IDX_MONDAY) begin
            cal_reg.mon <= wword[12:8];
            cal_reg.day <= wword[5:0];
         end
         if (wr_acc && avs_address_i == `RTC_IDX_YEARWK) begin
            cal_reg.wk <= wword[`RTC_WK_LSB +: 3];
            cal_reg.year <= wword[7:0];
         end
      end
   end

   // Stopwatch prescaler runs free so the run bit syncs to its edges
   assign sw_tick = sw_cnt_reg == SW_LAST;
   assign sw_count = sw_tick && sw_active_reg;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_cnt_reg <= 32'h0000_0000;
      end else begin
         sw_cnt_reg <= sw_tick ? 32'h0000_0000 : sw_cnt_reg + 32'h0000_0001;
      end
   end

   // Run bit takes effect at a stopwatch edge, so a stop may add one
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_active_reg <= 1'b0;
         sw_val_reg <= 8'h00;
      end else if (sw_tick) begin
         sw_active_reg <= sw_run_reg;
         if (sw_active_reg) begin
            sw_val_reg <= sw_val_reg == 8'h99 ? 8'h00
                                              : bcd_inc(sw_val_reg);
         end
      end
   end

   // Event sources, one per flag bit except bits 11..9, which are tied to zero
   assign flag_set = {regulation_done_i,
                      sw_count && sw_val_reg == 8'h99,
                      sw_count && sw_val_reg[3:0] == 4'h9,
                      sw_count, 3'b000, alarm_event_i,
                      cy.day, cy.hour, cy.min, sec_tick,
                      src_tick && div_reg[6:0] == 7'h7f,
                      src_tick && div_reg[5:0] == 6'h3f,
                      src_tick && div_reg[4:0] == 5'h1f,
                      src_tick && div_reg[2:0] == 3'h7};

   // Sticky flags: an event in the clearing cycle survives the clear
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_reg <= 16'h0000;
      end else if (wr_acc && avs_address_i == `RTC_IDX_FLAGS) begin
         flags_reg <= (flags_reg & ~(avs_writedata_i[15:0] & wmask)) |
                      flag_set;
      end else begin
         flags_reg <= flags_reg | flag_set;
      end
   end

   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign event_flags_o = flags_reg;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   sequence hm_read_s;
      avs_read_i && wait_reg && avs_address_i == `RTC_IDX_HURMIN;
   endsequence
   sequence divrst_write_s;
      wr_acc && avs_address_i == `RTC_IDX_CTRL &&
      wword[`RTC_CTRL_DIVRST];
   endsequence

   sw_hold_a: assert property (!sw_active_reg |=> $stable(sw_val_reg))
      else $error("stopwatch moved while stopped");
   sw_stop_a: assert property (sw_tick && !sw_run_reg |=> ##[0:1] 1'b1
      ##0 !sw_active_reg)
      else $error("stopwatch did not stop at its edge");
   sec_range_a: assert property (cal_reg.sec[6:4] <= 3'h5 &&
      cal_reg.sec[3:0] <= 4'h9)
      else $error("seconds out of range");
   div_step_a: assert property (src_tick && !divrst_reg |=>
      div_reg == $past(div_reg) + 8'h01)
      else $error("divider did not step");
   div_clear_a: assert property (divrst_write_s |=> divrst_reg
      ##1 (div_reg == 8'h00 && !divrst_reg))
      else $error("divider reset failed");
   pm_read24_a: assert property (hm_read_s ##0 mode24_reg |=>
      !rdata_reg[`RTC_PM_BIT])
      else $error("pm read as one in 24h mode");
   pm_clear_a: assert property (mode24_reg && cy.hour && !wr_acc |=>
      !cal_reg.pm)
      else $error("pm not cleared at hour step");
   hour_wrap_a: assert property (cy.hour && !mode24_reg && !wr_acc &&
      cal_reg.hour == 6'h12 |=> cal_reg.hour == 6'h01)
      else $error("12h wrap wrong");
   wk_range_a: assert property (cal_reg.wk <= 3'h6)
      else $error("weekday out of range");
   flag_keep_a: assert property (|flag_set |=>
      (flags_reg & $past(flag_set)) == $past(flag_set))
      else $error("event flag lost");
   sec_carry_a: assert property (sec_tick && cal_reg.sec == 7'h59 &&
      !wr_acc |=> cal_reg.sec == 7'h00 &&
      cal_reg.min != $past(cal_reg.min))
      else $error("second carry lost");

endmodule : rtc_calendar_counters

// ---- src/rtc_consts.svh ----
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// Word indices on the register bus (byte address = 4 * index)
`define RTC_IDX_CTRL 3'h0
`define RTC_IDX_SWCTL 3'h1
`define RTC_IDX_SEC 3'h2
`define RTC_IDX_HURMIN 3'h3
`define RTC_IDX_MONDAY 3'h4
`define RTC_IDX_YEARWK 3'h5
`define RTC_IDX_FLAGS 3'h6

// Control word fields
`define RTC_CTRL_RUN 0
`define RTC_CTRL_DIVRST 1
`define RTC_CTRL_24H 4
`define RTC_CTRL_BUSY 5
`define RTC_SW_RUN 0

// Field positions
`define RTC_PM_BIT 14
`define RTC_WK_LSB 8

// Reset values of the calendar
`define RTC_RST_HOUR 6'h12
`define RTC_RST_MON 5'h01
`define RTC_RST_DAY 6'h01

// Timing
`define RTC_CLK_HZ 100000000
`define RTC_SRC_HZ 256
`define RTC_SW_HZ 100
`define RTC_BUSY_CYCLES 4

`endif

// ---- src/rtc_pkg.sv ----
package rtc_pkg;

   // Calendar state, every field BCD except the weekday and the pm flag
   typedef struct packed {
      logic [6:0] sec;
      logic [6:0] min;
      logic [5:0] hour;
      logic pm;
      logic [5:0] day;
      logic [4:0] mon;
      logic [2:0] wk;
      logic [7:0] year;
   } calendar_t;

   // Carries rippling through the calendar in one cycle
   typedef struct packed {
      logic min;
      logic hour;
      logic day;
      logic mon;
   } carry_t;

endpackage : rtc_pkg

// ---- tb/rtc_calendar_counters_bench.sv ----
`timescale 1ns/1ns
`include "rtc_consts.svh"

module rtc_calendar_counters_bench;
   // Short ticks: one second is 256 * SRC cycles
   localparam int SRC = 4;
   localparam int SWT = 5;
   localparam int SECC = 256 * SRC;
   // Clock, reset, bus and events
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] adr = 3'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'h3;
   logic [31:0] rdat;
   logic wait_o;
   logic alarm = 1'b0;
   logic regd = 1'b0;
   logic [15:0] flags;
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;

   rtc_calendar_counters #(
      .SRC_TICK_CYCLES(SRC),
      .SW_TICK_CYCLES(SWT)
   ) u_dut (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .avs_address_i(adr),
      .avs_read_i(rd),
      .avs_write_i(wr),
      .avs_writedata_i(wdat),
      .avs_byteenable_i(be),
      .avs_readdata_o(rdat),
      .avs_waitrequest_o(wait_o),
      .alarm_event_i(alarm),
      .regulation_done_i(regd),
      .event_flags_o(flags)
   );

   // Clock generator
   always #5 clk_sys_i = ~clk_sys_i;

   // Hang guard, well above the roughly 8800 cycles of the run
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         complete_run();
      end
   end

   // Compare and count
   task check(input string what, input logic [31:0] seen,
              input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task wt(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : wt

   // One access, held until waitrequest is sampled low
   task bus(input logic w, input logic [2:0] a, input logic [15:0] d,
            output logic [31:0] q);
      adr <= a;
      wdat <= {16'h0, d};
      rd <= !w;
      wr <= w;
      @(posedge clk_sys_i);
      while (wait_o !== 1'b0) @(posedge clk_sys_i);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_sys_i);
   endtask : bus

   task wr16(input logic [2:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr16

   task rd16(input logic [2:0] a, output logic [31:0] q);
      bus(1'b0, a, 16'h0, q);
   endtask : rd16

   // Moving counters: repeat until two reads agree
   task rd_twice(input logic [2:0] a, output logic [31:0] q);
      logic [31:0] p;
      rd16(a, q);
      repeat (8) begin
         p = q;
         rd16(a, q);
         if (p === q) break;
      end
   endtask : rd_twice

   task ctl(input logic run, input logic m24, input logic dr);
      logic [15:0] c;
      c = 16'h0;
      c[`RTC_CTRL_RUN] = run;
      c[`RTC_CTRL_24H] = m24;
      c[`RTC_CTRL_DIVRST] = dr;
      wr16(`RTC_IDX_CTRL, c);
   endtask : ctl

   function automatic int b2(input logic [7:0] v);
      return v[7:4] * 10 + v[3:0];
   endfunction : b2

   // Set xx:59:59, run one second, stop, compare the calendar.
   // Written only while stopped, so busy never overlaps a write
   task roll(input logic pre, input logic m24, input logic [15:0] hm,
             input logic [15:0] md, input logic [15:0] yw,
             input logic [15:0] ehm, input logic [15:0] emd,
             input logic [15:0] eyw);
      logic [31:0] q;
      ctl(1'b0, pre, 1'b0);
      wr16(`RTC_IDX_SEC, 16'h5900);
      wr16(`RTC_IDX_HURMIN, hm);
      wr16(`RTC_IDX_MONDAY, md);
      wr16(`RTC_IDX_YEARWK, yw);
      ctl(1'b0, m24, 1'b1);
      ctl(1'b1, m24, 1'b0);
      wt(SECC + 60);
      ctl(1'b0, m24, 1'b0);
      rd16(`RTC_IDX_SEC, q);
      check("sec", q & 32'h7f00, 32'h0);
      rd16(`RTC_IDX_HURMIN, q);
      check("hurmin", q, {16'h0, ehm});
      rd16(`RTC_IDX_MONDAY, q);
      check("monday", q, {16'h0, emd});
      rd16(`RTC_IDX_YEARWK, q);
      check("yearwk", q, {16'h0, eyw});
   endtask : roll

   task t_reset();
      logic [31:0] q;
      logic [31:0] rv [8];
      rv = '{0, 0, 0, 32'h1200, 32'h0101, 0, 0, 0};
      for (int i = 0; i < 8; i++) begin
         rd16(i[2:0], q);
         check("reset", q, rv[i]);
      end
      wr16(3'h7, 16'hffff);
      rd16(3'h7, q);
      check("unmapped", q, 32'h0);
      // Lane 0 only: hour byte keeps its value
      be <= 4'h1;
      wr16(`RTC_IDX_HURMIN, 16'h5734);
      be <= 4'h3;
      rd16(`RTC_IDX_HURMIN, q);
      check("lane", q, 32'h1234);
   endtask : t_reset

   task t_regs();
      logic [31:0] q;
      // Low byte is the read-only divider; seconds stay in range
      wr16(`RTC_IDX_SEC, 16'h59ff);
      rd16(`RTC_IDX_SEC, q);
      check("sec ro", q, 32'h5900);
      wr16(`RTC_IDX_HURMIN, 16'h5159);
      rd16(`RTC_IDX_HURMIN, q);
      check("pm 12h", q, 32'h5159);
      wr16(`RTC_IDX_MONDAY, 16'h1231);
      rd16(`RTC_IDX_MONDAY, q);
      check("month", q, 32'h1231);
      wr16(`RTC_IDX_YEARWK, 16'h0699);
      rd16(`RTC_IDX_YEARWK, q);
      check("year", q, 32'h0699);
   endtask : t_regs

   task t_rolls();
      logic [31:0] q;
      roll(1, 1, 16'h2359, 16'h1231, 16'h0699,
           16'h0000, 16'h0101, 16'h0000);
      rd16(`RTC_IDX_FLAGS, q);
      check("ticks", q & 32'h00f0, 32'h00f0);
      wr16(`RTC_IDX_FLAGS, 16'h00ff);
      rd16(`RTC_IDX_FLAGS, q);
      check("w1c", q & 32'h00ff, 32'h0);
      roll(1, 1, 16'h2359, 16'h0228, 16'h0001,
           16'h0000, 16'h0301, 16'h0101);
      roll(1, 1, 16'h2359, 16'h0228, 16'h0004,
           16'h0000, 16'h0229, 16'h0104);
      roll(1, 1, 16'h2359, 16'h0430, 16'h0004,
           16'h0000, 16'h0501, 16'h0104);
      roll(0, 0, 16'h5159, 16'h0115, 16'h0210,
           16'h1200, 16'h0116, 16'h0310);
      roll(0, 0, 16'h1159, 16'h0115, 16'h0210,
           16'h5200, 16'h0115, 16'h0210);
   endtask : t_rolls

   task t_half_day();
      logic [31:0] q;
      ctl(1'b0, 1'b0, 1'b0);
      wr16(`RTC_IDX_HURMIN, 16'h4859);
      ctl(1'b0, 1'b1, 1'b0);
      rd16(`RTC_IDX_HURMIN, q);
      check("stale pm", q, 32'h0859);
      wr16(`RTC_IDX_HURMIN, 16'h4523);
      rd16(`RTC_IDX_HURMIN, q);
      check("pm 24h", q, 32'h0523);
      // Stale pm set in 12h, then an hour step in 24h
      roll(0, 1, 16'h4859, 16'h0110, 16'h0010,
           16'h0900, 16'h0110, 16'h0010);
      ctl(1'b0, 1'b0, 1'b0);
      rd16(`RTC_IDX_HURMIN, q);
      check("pm cleared", q, 32'h0900);
   endtask : t_half_day

   task t_divider();
      logic [31:0] q;
      ctl(1'b0, 1'b0, 1'b1);
      rd16(`RTC_IDX_SEC, q);
      check("div clr", q & 32'hff, 32'h0);
      // About 77 steps: 2 Hz stage set, 1 Hz stage clear
      ctl(1'b1, 1'b0, 1'b0);
      wt(300);
      rd_twice(`RTC_IDX_SEC, q);
      check("div 1", q & 32'hc0, 32'h40);
      wt(300);
      rd_twice(`RTC_IDX_SEC, q);
      check("div 2", q & 32'h80, 32'h80);
      ctl(1'b0, 1'b0, 1'b0);
   endtask : t_divider

   task t_stopwatch();
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      int d;
      wr16(`RTC_IDX_SWCTL, 16'h1);
      wt(100);
      wr16(`RTC_IDX_SWCTL, 16'h0);
      rd16(`RTC_IDX_SWCTL, a);
      wt(3 * SWT);
      rd16(`RTC_IDX_SWCTL, b);
      wt(40);
      rd16(`RTC_IDX_SWCTL, c);
      check("sw hold", c, b);
      d = b2(b[15:8]) - b2(a[15:8]);
      check("sw stop", 32'(d >= 0 && d <= 1), 32'h1);
      d = b2(b[15:8]);
      check("sw run", 32'(d >= 18 && d <= 23), 32'h1);
      wr16(`RTC_IDX_SWCTL, 16'h1);
      wt(50);
      wr16(`RTC_IDX_SWCTL, 16'h0);
      wt(3 * SWT);
      rd16(`RTC_IDX_SWCTL, c);
      d = b2(c[15:8]) - b2(b[15:8]);
      check("sw resume", 32'(d >= 8 && d <= 12), 32'h1);
   endtask : t_stopwatch

   task t_flags();
      logic [31:0] q;
      @(posedge clk_sys_i);
      alarm <= 1'b1;
      regd <= 1'b1;
      @(posedge clk_sys_i);
      alarm <= 1'b0;
      regd <= 1'b0;
      wt(2);
      check("pins", {16'h0, flags & 16'h8100}, 32'h8100);
      wr16(`RTC_IDX_FLAGS, 16'h0000);
      rd16(`RTC_IDX_FLAGS, q);
      check("w0", q & 32'h8100, 32'h8100);
      wr16(`RTC_IDX_FLAGS, 16'h0100);
      rd16(`RTC_IDX_FLAGS, q);
      check("w1 alarm", q & 32'h8100, 32'h8000);
      wr16(`RTC_IDX_FLAGS, 16'h8000);
      rd16(`RTC_IDX_FLAGS, q);
      check("w1 reg", q & 32'h8100, 32'h0);
   endtask : t_flags

   // Verdict and end of run
   task complete_run();
      $display("Checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run

   // Main sequence
   initial begin
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      t_reset();
      t_regs();
      t_rolls();
      t_half_day();
      t_divider();
      t_stopwatch();
      t_flags();
      complete_run();
   end
endmodule : rtc_calendar_counters_bench
